// ---- hw/tldsf_top.sv ----
`timescale 1ns/100ps
`include "tldsf_defines.svh"

module tldsf_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          push, pop;

  assign in_ready  = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_ptr_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb
  begin
    wr_ptr_d = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
    rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
    cnt_d    = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
    end
    else
    begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      cnt_q    <= cnt_d;
    end
  end

  for (genvar i = 0; i < D; i++)
  begin : g_ent
    always_ff @(posedge mclk)
    begin
      if (push && wr_ptr_q == AW'(i))
        mem_q[i] <= in_data;
    end
  end
endmodule // tldsf_fifo

module tldsf_top (
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  input  wire tldsf_pkg::tldsf_req_t  req,
  output logic [7:0]                  rd_data_q,
  input  wire tldsf_pkg::tldsf_hs_t   hs,
  input  wire logic [7:0]             rx_byte,
  output logic [7:0]                  tx_data_q,
  output logic                        tx_valid_q,
  input  wire logic                   tx_ready,
  output logic                        irq_q,
  output logic                        dma_out_req_q,
  output logic                        dma_in_req_q
);
  import tldsf_pkg::*;

  logic       err_q, err_d, do_q, do_d, bin_q, bin_d;
  logic       err_ie_q, err_ie_d, byte_out_ready_irq_en_q, byte_out_ready_irq_en_d, bin_ie_q, bin_ie_d;
  logic       dmao_q, dmao_d, dmai_q, dmai_d;
  logic       talk_rdy, talk_rdy_q, sdys_prev_q, wr_prev_q;
  logic       rd_stat1, rd_dir, wr_obr, wr_mask1, wr_mask2;
  logic       err_set, do_set, bin_set, bin_clr;
  logic [7:0] rd_data_d, obr_data_q, obr_data_d;
  logic       obr_valid_q, obr_valid_d;
  logic       fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [7:0] fifo_out_data, tx_data_d;
  logic       tx_valid_d, irq_d, dma_out_req_d, dma_in_req_d;

  assign rd_stat1 = req.rd & (req.addr == `TLDSF_ADDR_STAT1);
  assign rd_dir   = req.rd & (req.addr == `TLDSF_ADDR_DATA);
  assign wr_obr   = req.wr & (req.addr == `TLDSF_ADDR_DATA);
  assign wr_mask1 = req.wr & (req.addr == `TLDSF_ADDR_STAT1);
  assign wr_mask2 = req.wr & (req.addr == `TLDSF_ADDR_MASK2);
  assign talk_rdy = hs.tacs & hs.sgns;

  always_comb
  begin
    // Lost byte: sent with nobody listening, or written while source idle or in delay just before idle
    // error set terms
    // Third term: write made in delay state caught by the passage to idle
    err_set = (hs.tacs & hs.sdys & hs.dac & hs.rfd)
            | (wr_obr & hs.sids)
            | (wr_prev_q & sdys_prev_q & hs.sids);
    do_set  = talk_rdy & ~talk_rdy_q;
    bin_set = hs.lacs & hs.acds & hs.cont_mode;
    bin_clr = rd_stat1 | (hs.finish_hs & hs.holdoff) | rd_dir;
    err_d   = err_set | (err_q & ~rd_stat1);
    do_d    = do_set | (do_q & ~rd_stat1 & talk_rdy & ~wr_obr);
    bin_d   = bin_set | (bin_q & ~bin_clr);
  end

  always_comb
  begin
    // mask one shares the status address
    err_ie_d = wr_mask1 ? req.wdata[`TLDSF_BIT_ERR] : err_ie_q;
    byte_out_ready_irq_en_d  = wr_mask1 ? req.wdata[`TLDSF_BIT_DO] : byte_out_ready_irq_en_q;
    bin_ie_d = wr_mask1 ? req.wdata[`TLDSF_BIT_BYTE_IN] : bin_ie_q;
    dmao_d   = wr_mask2 ? req.wdata[`TLDSF_BIT_DMA_OUT] : dmao_q;
    dmai_d   = wr_mask2 ? req.wdata[`TLDSF_BIT_DMAI] : dmai_q;
    rd_data_d = `TLDSF_ZERO8;
    if (rd_stat1)
    begin
      rd_data_d[`TLDSF_BIT_ERR]     = err_q;
      rd_data_d[`TLDSF_BIT_DO]      = do_q;
      rd_data_d[`TLDSF_BIT_BYTE_IN] = bin_q;
    end
    else if (rd_dir)
      rd_data_d = rx_byte;
    irq_d         = (err_q & err_ie_q) | (do_q & byte_out_ready_irq_en_q) | (bin_q & bin_ie_q);
    dma_out_req_d = do_q & dmao_q;
    dma_in_req_d  = bin_q & dmai_q;
  end

  always_comb
  begin
    // Write while the previous byte waits for FIFO room is dropped
    obr_valid_d = obr_valid_q;
    obr_data_d  = obr_data_q;
    if (obr_valid_q && fifo_in_ready)
      obr_valid_d = 1'b0;
    if (wr_obr && (!obr_valid_q || fifo_in_ready))
    begin
      obr_valid_d = 1'b1;
      obr_data_d  = req.wdata;
    end
    tx_valid_d = tx_valid_q & ~tx_ready;
    tx_data_d  = tx_data_q;
    if (fifo_out_valid && fifo_out_ready)
    begin
      tx_valid_d = 1'b1;
      tx_data_d  = fifo_out_data;
    end
  end

  assign fifo_out_ready = ~tx_valid_q | tx_ready;

  tldsf_fifo #(
    .W (`TLDSF_BYTE_W),
    .D (`TLDSF_FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .in_valid  (obr_valid_q),
    .in_ready  (fifo_in_ready),
    .in_data   (obr_data_q),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      err_q         <= 1'b0;
      do_q          <= 1'b0;
      bin_q         <= 1'b0;
      err_ie_q      <= 1'b0;
      byte_out_ready_irq_en_q       <= 1'b0;
      bin_ie_q      <= 1'b0;
      dmao_q        <= 1'b0;
      dmai_q        <= 1'b0;
      talk_rdy_q    <= 1'b0;
      sdys_prev_q   <= 1'b0;
      wr_prev_q     <= 1'b0;
      rd_data_q     <= `TLDSF_ZERO8;
      obr_valid_q   <= 1'b0;
      obr_data_q    <= `TLDSF_ZERO8;
      tx_valid_q    <= 1'b0;
      tx_data_q     <= `TLDSF_ZERO8;
      irq_q         <= 1'b0;
      dma_out_req_q <= 1'b0;
      dma_in_req_q  <= 1'b0;
    end
    else
    begin
      err_q         <= err_d;
      do_q          <= do_d;
      bin_q         <= bin_d;
      err_ie_q      <= err_ie_d;
      byte_out_ready_irq_en_q       <= byte_out_ready_irq_en_d;
      bin_ie_q      <= bin_ie_d;
      dmao_q        <= dmao_d;
      dmai_q        <= dmai_d;
      talk_rdy_q    <= talk_rdy;
      sdys_prev_q   <= hs.sdys;
      wr_prev_q     <= wr_obr;
      rd_data_q     <= rd_data_d;
      obr_valid_q   <= obr_valid_d;
      obr_data_q    <= obr_data_d;
      tx_valid_q    <= tx_valid_d;
      tx_data_q     <= tx_data_d;
      irq_q         <= irq_d;
      dma_out_req_q <= dma_out_req_d;
      dma_in_req_q  <= dma_in_req_d;
    end
  end

  sequence s_talk_rise;
    !talk_rdy ##1 talk_rdy;
  endsequence
  sequence s_stat1_read;
    rd_stat1 && !err_set;
  endsequence

  property p_err_nolistener;
    @(posedge mclk) disable iff (sys_rst) (hs.tacs && hs.sdys && hs.dac && hs.rfd) |=> err_q;
  endproperty
  a_err_nolistener: assert property (p_err_nolistener) else $error("error flag missed unheard byte");

  property p_err_idle_write;
    @(posedge mclk) disable iff (sys_rst) (wr_obr && hs.sids) |=> err_q ##1 (err_q || $past(rd_stat1));
  endproperty
  a_err_idle_write: assert property (p_err_idle_write) else $error("error flag missed idle write");

  property p_err_clear;
    @(posedge mclk) disable iff (sys_rst) s_stat1_read |=> !err_q;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error flag not cleared by read");

  property p_do_rise;
    @(posedge mclk) disable iff (sys_rst) s_talk_rise |=> do_q;
  endproperty
  a_do_rise: assert property (p_do_rise) else $error("data-out flag not set on talk ready");

  property p_do_leave;
    @(posedge mclk) disable iff (sys_rst) !talk_rdy |=> !do_q;
  endproperty
  a_do_leave: assert property (p_do_leave) else $error("data-out flag held outside talk ready");

  property p_do_write;
    @(posedge mclk) disable iff (sys_rst) (do_q && wr_obr && !do_set) |=> !do_q;
  endproperty
  a_do_write: assert property (p_do_write) else $error("data-out flag held after byte write");

  property p_dma_out;
    @(posedge mclk) disable iff (sys_rst) dma_out_req_q |-> $past(do_q) && $past(dmao_q);
  endproperty
  a_dma_out: assert property (p_dma_out) else $error("DMA request without data-out");

  property p_bin_set;
    @(posedge mclk) disable iff (sys_rst) (hs.lacs && hs.acds && hs.cont_mode) |=> bin_q;
  endproperty
  a_bin_set: assert property (p_bin_set) else $error("data-in flag not set");

  property p_bin_clear;
    @(posedge mclk) disable iff (sys_rst) (bin_clr && !bin_set) |=> !bin_q;
  endproperty
  a_bin_clear: assert property (p_bin_clear) else $error("data-in flag not cleared");

  property p_stat1_bits;
    @(posedge mclk) disable iff (sys_rst)
      rd_stat1 |=> rd_data_q[`TLDSF_BIT_DO] == $past(do_q) && rd_data_q[`TLDSF_BIT_BYTE_IN] == $past(bin_q);
  endproperty
  a_stat1_bits: assert property (p_stat1_bits) else $error("status read shows wrong bits");

  property p_irq;
    @(posedge mclk) disable iff (sys_rst)
      irq_q == $past((err_q && err_ie_q) || (do_q && byte_out_ready_irq_en_q) || (bin_q && bin_ie_q));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt does not follow enabled flags");

  property p_set_wins;
    @(posedge mclk) disable iff (sys_rst) (rd_stat1 && bin_set) |=> bin_q;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("data-in event lost during read");
endmodule // tldsf_top

// ---- inc/tldsf_defines.svh ----
`ifndef TLDSF_DEFINES_SVH
`define TLDSF_DEFINES_SVH
`define TLDSF_ADDR_DATA   2'h0
`define TLDSF_ADDR_STAT1  2'h1
`define TLDSF_ADDR_MASK2  2'h2
`define TLDSF_BIT_ERR     2
`define TLDSF_BIT_DO      1
`define TLDSF_BIT_BYTE_IN 0
`define TLDSF_BIT_DMA_OUT 5
`define TLDSF_BIT_DMAI    4
`define TLDSF_BYTE_W      8
`define TLDSF_FIFO_DEPTH  8
`define TLDSF_ZERO8       8'h00
`endif

// ---- inc/tldsf_pkg.sv ----
package tldsf_pkg;
  // Handshake state levels, same clock as this block
  typedef struct packed {
    logic tacs;
    logic sgns;
    logic sdys;
    logic sids;
    logic dac;
    logic rfd;
    logic lacs;
    logic acds;
    logic cont_mode;
    logic holdoff;
    logic finish_hs;
  } tldsf_hs_t;

  // Host register port request
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [1:0] addr;
    logic [7:0] wdata;
  } tldsf_req_t;
endpackage

// ---- dv/tldsf_src_model.sv ----
`timescale 1ns/100ps

module tldsf_src_model (
  input  wire logic mclk,
  input  wire logic stall,
  output logic      tx_ready
);
  // Takes bytes with random gaps, never while stalled
  initial tx_ready = 1'b0;
  always @(posedge mclk)
  begin
    tx_ready <= #1 !stall && ($urandom % 3 != 0);
  end
endmodule // tldsf_src_model

// ---- dv/tb.sv ----
`timescale 1ns/100ps

module tb;
  import tldsf_pkg::*;
  logic       mclk    = 1'b0;
  logic       sys_rst = 1'b1;
  tldsf_req_t req     = '0;
  tldsf_hs_t  hs      = '0;
  logic [7:0] rx_byte = 8'h3c;
  logic       stall   = 1'b0;
  logic       rd_seen = 1'b0;
  logic [7:0] rd_data_q;
  logic [7:0] tx_data_q;
  logic       tx_valid_q;
  logic       tx_ready;
  logic       irq_q;
  logic       dma_out_req_q;
  logic       dma_in_req_q;
  logic [7:0] rd_exp[$];
  logic [7:0] tx_exp[$];
  logic [7:0] d;
  int         miscompares = 0;
  int         num_checks  = 0;

  always #10 mclk = ~mclk;

  tldsf_top uut (
    .mclk(mclk), .sys_rst(sys_rst), .req(req), .rd_data_q(rd_data_q), .hs(hs), .rx_byte(rx_byte),
    .tx_data_q(tx_data_q), .tx_valid_q(tx_valid_q), .tx_ready(tx_ready), .irq_q(irq_q),
    .dma_out_req_q(dma_out_req_q), .dma_in_req_q(dma_in_req_q)
  );

  tldsf_src_model peer (.mclk(mclk), .stall(stall), .tx_ready(tx_ready));

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic chk_rd(input logic [7:0] exp, input logic [7:0] got);
    chk("read data", exp, got);
  endtask

  task automatic chk_tx(input logic [7:0] exp, input logic [7:0] got);
    chk("tx byte", exp, got);
  endtask

  task automatic chk_lvl(input string name, input logic exp, input logic got);
    chk(name, {7'h00, exp}, {7'h00, got});
  endtask

  task automatic end_sim();
    $display("checks %0d, miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    cyc(1);
    req.wr    = 1'b1;
    req.addr  = a;
    req.wdata = v;
    cyc(1);
    req.wr = 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    cyc(1);
    req.rd   = 1'b1;
    req.addr = a;
    rd_exp.push_back(e);
    cyc(1);
    req.rd = 1'b0;
  endtask

  // Result watcher: read answers and accepted bytes against the notes
  always @(posedge mclk) rd_seen <= req.rd;
  always @(negedge mclk)
  begin
    if (rd_seen)
      chk_rd(rd_exp.pop_front(), rd_data_q);
    if (tx_valid_q && tx_ready && tx_exp.size() > 0)
      chk_tx(tx_exp.pop_front(), tx_data_q);
  end

  initial
  begin
    void'($urandom(3));
    rx_byte = 8'($urandom);
    cyc(3);
    sys_rst = 1'b0;
    rd(1, 8'h00);
    hs.sids = 1'b1;
    wr(0, 8'h5a);
    hs.sids = 1'b0;
    rd(1, 8'h04);
    rd(1, 8'h00);
    hs.tacs = 1'b1;
    hs.sdys = 1'b1;
    hs.dac  = 1'b1;
    hs.rfd  = 1'b1;
    cyc(1);
    hs = '0;
    rd(1, 8'h04);
    hs.tacs = 1'b1;
    hs.sgns = 1'b1;
    rd(1, 8'h02);
    rd(1, 8'h00);
    hs.sgns = 1'b0;
    cyc(2);
    hs.sgns = 1'b1;
    wr(0, 8'h11);
    rd(1, 8'h00);
    hs.sgns = 1'b0;
    cyc(2);
    hs.sgns = 1'b1;
    cyc(2);
    hs.tacs = 1'b0;
    rd(1, 8'h00);
    wr(1, 8'h02);
    hs.tacs = 1'b1;
    cyc(3);
    chk_lvl("irq", 1'b1, irq_q);
    wr(2, 8'h20);
    wr(1, 8'h00);
    cyc(3);
    chk_lvl("irq", 1'b0, irq_q);
    chk_lvl("dma out", 1'b1, dma_out_req_q);
    rd(1, 8'h02);
    cyc(3);
    chk_lvl("dma out", 1'b0, dma_out_req_q);
    hs = '0;
    hs.lacs = 1'b1;
    hs.acds = 1'b1;
    cyc(2);
    rd(1, 8'h00);
    hs.cont_mode = 1'b1;
    wr(1, 8'h01);
    cyc(2);
    chk_lvl("irq", 1'b1, irq_q);
    hs.acds = 1'b0;
    rd(0, rx_byte);
    rd(1, 8'h00);
    hs.acds = 1'b1;
    cyc(2);
    hs.acds      = 1'b0;
    hs.holdoff   = 1'b1;
    hs.finish_hs = 1'b1;
    cyc(1);
    hs.finish_hs = 1'b0;
    cyc(1);
    rd(1, 8'h00);
    hs.acds = 1'b1;
    cyc(2);
    wr(2, 8'h10);
    cyc(2);
    chk_lvl("dma in", 1'b1, dma_in_req_q);
    rd(1, 8'h01);
    rd(1, 8'h01);
    hs = '0;
    rd(1, 8'h01);
    rd(1, 8'h00);
    cyc(2);
    chk_lvl("dma in", 1'b0, dma_in_req_q);
    wr(1, 8'h00);
    cyc(20);
    stall = 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      d = 8'($urandom);
      tx_exp.push_back(d);
      wr(0, d);
    end
    stall = 1'b0;
    for (int k = 0; k < 200 && tx_exp.size() > 0; k++)
      cyc(1);
    chk("tx left", 8'h00, 8'(tx_exp.size()));
    rd(1, 8'h00);
    cyc(3);
    end_sim();
  end
endmodule // tb
